// ==== verilog/tcov_pkg.sv ====
// constants and types shared by the time code overlay control block
// assumes one core clock and a synchronous active-high reset
package tcov_pkg;
  localparam int NUM_WIN = 6;
  localparam logic [2:0] FIRST_WIN = 3'h0;
  localparam logic [2:0] LAST_WIN = 3'h5;
  // window order: time, source id, gen user bits, lin rdr, vert rdr time, vert rdr ubits
  localparam logic [1:0] SIZE_TINY = 2'h0;
  localparam logic [1:0] SIZE_SMALL = 2'h1;
  localparam logic [1:0] SIZE_LARGE = 2'h2;
  localparam logic [5:0] LINES_TINY = 6'h08;
  localparam logic [5:0] LINES_SMALL = 6'h10;
  localparam logic [5:0] LINES_LARGE = 6'h20;
  localparam logic [4:0] ROWS_TINY = 5'h1E;
  localparam logic [4:0] ROWS_SMALL = 5'h0F;
  localparam logic [4:0] ROWS_LARGE = 5'h07;
  localparam logic [5:0] COL_MAX = 6'h27;
  localparam logic [4:0] ROW_RESET = 5'h00;
  localparam logic [5:0] COL_RESET = 6'h00;
  localparam logic [2:0] STYLE_WHITE = 3'h0;
  localparam logic [2:0] STYLE_WHITE_BLACK = 3'h1;
  localparam logic [2:0] STYLE_WHITE_GREY = 3'h2;
  localparam logic [2:0] STYLE_BLACK = 3'h3;
  localparam logic [2:0] STYLE_BLACK_WHITE = 3'h4;
  localparam logic [2:0] STYLE_BLACK_CLEAR = 3'h5;
  localparam logic [1:0] MODE_TIME_DATE = 2'h2;
  localparam logic signed [6:0] HOURS_DAY = 7'sh18;
  localparam logic [5:0] WIN_EN_RESET = 6'h3F;
  localparam logic OVERLAY_RESET = 1'b1;
  typedef enum logic {SEL_NORMAL, SEL_ACTIVE} tcov_sel_t;
endpackage : tcov_pkg

// ==== verilog/tcov_move_if.sv ====
// carrier between the overlay controller and the window position store
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface tcov_move_if;
  logic [5:0] moveMask;
  logic stepUp;
  logic stepDown;
  logic stepLeft;
  logic stepRight;
  logic [4:0] rowMax;
  logic [4:0] rowPos [6];
  logic [5:0] colPos [6];
  modport ctrl (output moveMask, stepUp, stepDown, stepLeft, stepRight, rowMax, input rowPos, colPos);
  modport store (input moveMask, stepUp, stepDown, stepLeft, stepRight, rowMax, output rowPos, colPos);
endinterface : tcov_move_if

// ==== verilog/tcov_win_pos.sv ====
// position store for the six overlay windows
// assumes one-cycle step pulses and a synchronous active-high reset
`timescale 1ns/1ps
module tcov_win_pos (
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset
  tcov_move_if.store mv // step requests and positions
);
  genvar gi;
  generate
    for (gi = 0; gi < tcov_pkg::NUM_WIN; gi++) begin : g_win
      logic [4:0] row_q;
      logic [4:0] row_d;
      logic [5:0] col_q;
      logic [5:0] col_d;
      always_comb begin
        row_d = row_q;
        col_d = col_q;
        if (mv.moveMask[gi]) begin
          if (mv.stepUp && row_q != 5'h00) begin
            row_d = row_q - 5'h01;
          end else if (mv.stepDown && row_q < mv.rowMax) begin
            row_d = row_q + 5'h01;
          end
          if (mv.stepLeft && col_q != 6'h00) begin
            col_d = col_q - 6'h01;
          end else if (mv.stepRight && col_q < tcov_pkg::COL_MAX) begin
            col_d = col_q + 6'h01;
          end
        end
        // a smaller raster grid pulls windows back inside it
        if (row_d > mv.rowMax) begin
          row_d = mv.rowMax;
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          row_q <= tcov_pkg::ROW_RESET;
          col_q <= tcov_pkg::COL_RESET;
        end else begin
          row_q <= row_d;
          col_q <= col_d;
        end
      end
      assign mv.rowPos[gi] = row_q;
      assign mv.colPos[gi] = col_q;
    end
  endgenerate
endmodule : tcov_win_pos

// ==== verilog/tcov_zone_adj.sv ====
// hour adjustment of the vertical reader time: utc or local with dst
// assumes binary hours 0..23 and a signed whole-hour zone offset
`timescale 1ns/1ps
module tcov_zone_adj (
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [4:0] utcHours, // reader hours as read
  input wire logic signed [4:0] zoneOffset, // programmed zone offset, hours
  input wire logic dstOn, // daylight saving in effect
  input wire logic [1:0] vertical_reader_content_mode, // reader content mode
  input wire logic vertical_reader_zone_select, // 1 = local, 0 = utc
  output logic [4:0] shownHours // hours to display
);
  logic [4:0] hours_q;
  logic [4:0] hours_d;
  logic signed [6:0] sum;
  always_comb begin
    sum = 7'(signed'({2'h0, utcHours})) + 7'(zoneOffset) + 7'(signed'({6'h00, dstOn}));
    hours_d = utcHours;
    if (vertical_reader_content_mode == tcov_pkg::MODE_TIME_DATE && vertical_reader_zone_select) begin
      if (sum < 7'sh00) begin
        hours_d = 5'(sum + tcov_pkg::HOURS_DAY);
      end else if (sum >= tcov_pkg::HOURS_DAY) begin
        hours_d = 5'(sum - tcov_pkg::HOURS_DAY);
      end else begin
        hours_d = 5'(sum);
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hours_q <= 5'h00;
    end else begin
      hours_q <= hours_d;
    end
  end
  assign shownHours = hours_q;
  zone_utc_a: assert property (@(posedge core_clk) disable iff (rst)
    (vertical_reader_content_mode != tcov_pkg::MODE_TIME_DATE || !vertical_reader_zone_select)
      |=> shownHours == $past(utcHours)) else $error("utc hours not passed through");
endmodule : tcov_zone_adj

// ==== verilog/tcov_ctrl.sv ====
// time code character overlay control: size, style, display toggles,
// window selection and movement, keyer on/off priority, reader zone
// assumes key inputs are one-cycle pulses synchronous to core_clk
`timescale 1ns/1ps
module tcov_ctrl (
  input wire logic core_clk, // system clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic keyWinSel, // window-select key pulse
  input wire logic keyOnOff, // keyer on/off key pulse
  input wire logic keyUp, // arrow up pulse
  input wire logic keyDown, // arrow down pulse
  input wire logic keyLeft, // arrow left pulse
  input wire logic keyRight, // arrow right pulse
  input wire logic remoteToggle, // rear remote keyer event pulse
  input wire logic [1:0] charSize, // tiny, small, large
  input wire logic [2:0] charStyle, // glyph and mask style
  input wire logic menuActive, // menu page on screen
  input wire logic showFrames, // frames display setting
  input wire logic showFields, // fields display setting
  input wire logic showSymbols, // symbols display setting
  input wire logic dropFrame, // code is drop frame
  input wire logic is525, // 525-line video
  input wire logic [4:0] rdrUtcHours, // vertical reader hours
  input wire logic signed [4:0] zoneOffset, // zone offset, hours
  input wire logic dstOn, // daylight saving in effect
  input wire logic [1:0] vertical_reader_content_mode, // reader mode
  input wire logic vertical_reader_zone_select, // 1 = local time
  output logic overlayOn, // global keyer state
  output logic selectMode, // window-select mode active
  output logic [5:0] winHighlight, // one-hot highlighted window
  output logic [5:0] winVisible, // windows keyed into picture
  output logic [5:0] winEnabled, // per-window enables
  output logic [29:0] winRowFlat, // 5-bit row per window
  output logic [35:0] winColFlat, // 6-bit column per window
  output logic [5:0] rowLines, // lines per field per row
  output logic [4:0] rowCount, // vertical row positions
  output logic glyphWhite, // glyphs white, else black
  output logic maskOn, // background mask drawn
  output logic maskOpaque, // mask opaque, else transparent
  output logic maskWhite, // mask white, else black or grey
  output logic frameDigitsOn, // frame digits drawn
  output logic fieldMarkOn, // field mark drawn
  output logic symbolsOn, // separators drawn
  output logic sepIsPeriod, // seconds-frames separator is period
  output logic [4:0] rdrShownHours // vertical reader hours shown
);
  // ************************************************************
  // selection state
  // ************************************************************
  tcov_pkg::tcov_sel_t sel_q;
  tcov_pkg::tcov_sel_t sel_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic on_q;
  logic on_d;
  logic [5:0] en_q;
  logic [5:0] en_d;
  logic toggleAll;

  always_comb begin
    sel_d = sel_q;
    idx_d = idx_q;
    on_d = on_q;
    en_d = en_q;
    // both sources in one cycle merge into a single toggle
    toggleAll = remoteToggle || (keyOnOff && sel_q == tcov_pkg::SEL_NORMAL);
    if (toggleAll) begin
      on_d = !on_q;
    end
    if (keyOnOff && sel_q == tcov_pkg::SEL_ACTIVE) begin
      en_d[idx_q] = !en_q[idx_q];
    end
    if (keyWinSel) begin
      case (sel_q)
        tcov_pkg::SEL_NORMAL: begin
          sel_d = tcov_pkg::SEL_ACTIVE;
          idx_d = tcov_pkg::FIRST_WIN;
        end
        tcov_pkg::SEL_ACTIVE: begin
          if (idx_q == tcov_pkg::LAST_WIN) begin
            sel_d = tcov_pkg::SEL_NORMAL;
            idx_d = tcov_pkg::FIRST_WIN;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
        default: begin
          sel_d = tcov_pkg::SEL_NORMAL;
          idx_d = tcov_pkg::FIRST_WIN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_q <= tcov_pkg::SEL_NORMAL;
      idx_q <= tcov_pkg::FIRST_WIN;
      on_q <= tcov_pkg::OVERLAY_RESET;
      en_q <= tcov_pkg::WIN_EN_RESET;
    end else begin
      sel_q <= sel_d;
      idx_q <= idx_d;
      on_q <= on_d;
      en_q <= en_d;
    end
  end

  assign overlayOn = on_q;
  assign selectMode = (sel_q == tcov_pkg::SEL_ACTIVE);
  assign winEnabled = en_q;
  assign winHighlight = selectMode ? (6'h01 << idx_q) : 6'h00;
  // global state ranks above the per-window enables
  assign winVisible = on_q ? (selectMode ? 6'h3F : en_q) : 6'h00;

  // ************************************************************
  // window movement
  // ************************************************************
  tcov_move_if mv ();
  assign mv.moveMask = selectMode ? winHighlight : winVisible;
  assign mv.stepUp = keyUp;
  assign mv.stepDown = keyDown;
  assign mv.stepLeft = keyLeft;
  assign mv.stepRight = keyRight;
  assign mv.rowMax = rowCount - 5'h01;

  tcov_win_pos u_pos (
    .core_clk (core_clk),
    .rst (rst),
    .mv (mv.store)
  );

  genvar gw;
  generate
    for (gw = 0; gw < tcov_pkg::NUM_WIN; gw++) begin : g_flat
      assign winRowFlat[gw*5 +: 5] = mv.rowPos[gw];
      assign winColFlat[gw*6 +: 6] = mv.colPos[gw];
    end
  endgenerate

  // ************************************************************
  // size, style and display settings
  // ************************************************************
  logic [5:0] lines_q;
  logic [5:0] lines_d;
  logic [4:0] rows_q;
  logic [4:0] rows_d;
  logic [3:0] look_q;
  logic [3:0] look_d;
  logic [3:0] show_q;
  logic [3:0] show_d;

  always_comb begin
    case (charSize)
      tcov_pkg::SIZE_TINY: begin
        lines_d = tcov_pkg::LINES_TINY;
        rows_d = tcov_pkg::ROWS_TINY;
      end
      tcov_pkg::SIZE_LARGE: begin
        lines_d = tcov_pkg::LINES_LARGE;
        rows_d = tcov_pkg::ROWS_LARGE;
      end
      default: begin
        lines_d = tcov_pkg::LINES_SMALL;
        rows_d = tcov_pkg::ROWS_SMALL;
      end
    endcase
    // look: glyph white, mask on, mask opaque, mask white
    if (menuActive) begin
      look_d = 4'hE;
    end else begin
      case (charStyle)
        tcov_pkg::STYLE_WHITE_BLACK: look_d = 4'hE;
        tcov_pkg::STYLE_WHITE_GREY: look_d = 4'hC;
        tcov_pkg::STYLE_BLACK: look_d = 4'h0;
        tcov_pkg::STYLE_BLACK_WHITE: look_d = 4'h7;
        tcov_pkg::STYLE_BLACK_CLEAR: look_d = 4'h5;
        default: look_d = 4'h8;
      endcase
    end
    show_d[3] = showFrames;
    show_d[2] = showFields;
    show_d[1] = showSymbols;
    show_d[0] = showSymbols && dropFrame && is525;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lines_q <= tcov_pkg::LINES_SMALL;
      rows_q <= tcov_pkg::ROWS_SMALL;
      look_q <= 4'hE;
      show_q <= 4'h0;
    end else begin
      lines_q <= lines_d;
      rows_q <= rows_d;
      look_q <= look_d;
      show_q <= show_d;
    end
  end

  assign rowLines = lines_q;
  assign rowCount = rows_q;
  assign glyphWhite = look_q[3];
  assign maskOn = look_q[2];
  assign maskOpaque = look_q[1];
  assign maskWhite = look_q[0];
  assign frameDigitsOn = show_q[3];
  assign fieldMarkOn = show_q[2];
  assign symbolsOn = show_q[1];
  assign sepIsPeriod = show_q[0];

  // ************************************************************
  // vertical reader zone adjustment
  // ************************************************************
  tcov_zone_adj u_zone (
    .core_clk (core_clk),
    .rst (rst),
    .utcHours (rdrUtcHours),
    .zoneOffset (zoneOffset),
    .dstOn (dstOn),
    .vertical_reader_content_mode (vertical_reader_content_mode),
    .vertical_reader_zone_select (vertical_reader_zone_select),
    .shownHours (rdrShownHours)
  );

  // ************************************************************
  // checks
  // ************************************************************
  sel_enter_a: assert property (@(posedge core_clk) disable iff (rst)
    (keyWinSel && !selectMode) |=> (selectMode && winHighlight == 6'h01 && (winVisible == 6'h3F || !overlayOn)))
    else $error("select mode not entered on time window");
  sel_next_a: assert property (@(posedge core_clk) disable iff (rst)
    (keyWinSel && selectMode && idx_q != tcov_pkg::LAST_WIN) |=> (selectMode && idx_q == $past(idx_q) + 3'h1))
    else $error("highlight did not step");
  sel_leave_a: assert property (@(posedge core_clk) disable iff (rst)
    (keyWinSel && selectMode && idx_q == tcov_pkg::LAST_WIN) |=> (!selectMode && winHighlight == 6'h00))
    else $error("select mode not left after last window");
  move_one_a: assert property (@(posedge core_clk) disable iff (rst)
    selectMode |-> (mv.moveMask == winHighlight && $onehot(mv.moveMask)))
    else $error("select mode moves other windows");
  move_all_a: assert property (@(posedge core_clk) disable iff (rst)
    (!selectMode && overlayOn) |-> (mv.moveMask == winEnabled))
    else $error("normal mode does not move all shown windows");
  key_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
    (keyOnOff && !selectMode) |=> (overlayOn == !$past(overlayOn)))
    else $error("front key did not toggle overlay");
  remote_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
    remoteToggle |=> (overlayOn == !$past(overlayOn)))
    else $error("remote event did not toggle overlay once");
  win_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
    (keyOnOff && selectMode && !remoteToggle) |=>
      (overlayOn == $past(overlayOn) && winEnabled == ($past(winEnabled) ^ $past(winHighlight))))
    else $error("window toggle wrong");
  menu_look_a: assert property (@(posedge core_clk) disable iff (rst)
    menuActive |=> (glyphWhite && maskOn && maskOpaque && !maskWhite))
    else $error("menu not white on black");
  size_tiny_a: assert property (@(posedge core_clk) disable iff (rst)
    (charSize == tcov_pkg::SIZE_TINY) |=> (rowLines == 6'h08 && rowCount == 5'h1E))
    else $error("tiny size grid wrong");
  size_large_a: assert property (@(posedge core_clk) disable iff (rst)
    (charSize == tcov_pkg::SIZE_LARGE) |=> (rowLines == 6'h20 && rowCount == 5'h07))
    else $error("large size grid wrong");
  size_small_a: assert property (@(posedge core_clk) disable iff (rst)
    (charSize == tcov_pkg::SIZE_SMALL) |=> (rowLines == 6'h10 && rowCount == 5'h0F))
    else $error("small size grid wrong");
  black_look_a: assert property (@(posedge core_clk) disable iff (rst)
    (!menuActive && charStyle == tcov_pkg::STYLE_BLACK_WHITE) |=> (!glyphWhite && maskOpaque && maskWhite))
    else $error("black on white style wrong");
  sep_mark_a: assert property (@(posedge core_clk) disable iff (rst)
    (showSymbols && !is525) |=> !sepIsPeriod)
    else $error("drop frame period outside 525");
  hide_frames_a: assert property (@(posedge core_clk) disable iff (rst)
    !showFrames |=> !frameDigitsOn)
    else $error("frame digits not hidden");
  show_fields_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> (fieldMarkOn == $past(showFields)))
    else $error("field mark does not follow setting");
  show_symbols_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> (symbolsOn == $past(showSymbols)))
    else $error("symbols do not follow setting");
  sep_period_a: assert property (@(posedge core_clk) disable iff (rst)
    (showSymbols && dropFrame && is525) |=> sepIsPeriod)
    else $error("drop frame separator not period");
  white_grey_a: assert property (@(posedge core_clk) disable iff (rst)
    (!menuActive && charStyle == tcov_pkg::STYLE_WHITE_GREY) |=> (glyphWhite && maskOn && !maskOpaque && !maskWhite))
    else $error("white on grey style wrong");
  global_off_a: assert property (@(posedge core_clk) disable iff (rst)
    !overlayOn |-> (winVisible == 6'h00))
    else $error("window shown with overlay off");
endmodule : tcov_ctrl

// ==== verification/tcov_keypad_model.sv ====
// front panel keypad and rear remote keyer input of the overlay control
// assumes the bench calls press() and that core_clk is free running
`timescale 1ns/1ps
module tcov_keypad_model (
  input wire logic core_clk, // system clock
  output logic keyWinSel, // window-select key pulse
  output logic keyOnOff, // keyer on/off key pulse
  output logic keyUp, // arrow up pulse
  output logic keyDown, // arrow down pulse
  output logic keyLeft, // arrow left pulse
  output logic keyRight, // arrow right pulse
  output logic remoteToggle // remote keyer event pulse
);
  initial begin
    {keyWinSel, keyOnOff, keyUp, keyDown, keyLeft, keyRight, remoteToggle} = 7'h00;
  end
  // one discrete event: keys high for exactly one cycle, then idle low
  task automatic press(input logic [6:0] keys);
    @(negedge core_clk);
    {keyWinSel, keyOnOff, keyUp, keyDown, keyLeft, keyRight, remoteToggle} = keys;
    @(negedge core_clk);
    {keyWinSel, keyOnOff, keyUp, keyDown, keyLeft, keyRight, remoteToggle} = 7'h00;
    @(negedge core_clk);
    @(negedge core_clk);
  endtask : press
endmodule : tcov_keypad_model

// ==== verification/tb_timecode_char_overlay_control.sv ====
// self-checking bench of the time code overlay control
// assumes the keypad model drives all key inputs, settings driven here
`timescale 1ns/1ps
module tb_timecode_char_overlay_control;
  localparam logic [6:0] K_SEL = 7'h40;
  localparam logic [6:0] K_ONOFF = 7'h20;
  localparam logic [6:0] K_UP = 7'h10;
  localparam logic [6:0] K_DOWN = 7'h08;
  localparam logic [6:0] K_LEFT = 7'h04;
  localparam logic [6:0] K_RIGHT = 7'h02;
  localparam logic [6:0] K_REMOTE = 7'h01;
  logic core_clk, rst;
  logic keyWinSel, keyOnOff, keyUp, keyDown, keyLeft, keyRight, remoteToggle;
  logic [1:0] charSize, mode;
  logic [2:0] charStyle;
  logic menuActive, showFrames, showFields, showSymbols, dropFrame, is525, dstOn, zoneSel;
  logic [4:0] rdrUtcHours;
  logic signed [4:0] zoneOffset;
  logic overlayOn, selectMode, glyphWhite, maskOn, maskOpaque, maskWhite;
  logic frameDigitsOn, fieldMarkOn, symbolsOn, sepIsPeriod;
  logic [5:0] winHighlight, winVisible, winEnabled, rowLines;
  logic [29:0] winRowFlat;
  logic [35:0] winColFlat;
  logic [4:0] rowCount, rdrShownHours;
  int fails, checkCount;
  logic [3:0] styleExp [6] = '{4'h8, 4'hE, 4'hC, 4'h0, 4'h7, 4'h5};
  logic [4:0] flagIn [3] = '{5'h17, 5'h0E, 5'h0B};
  logic [3:0] flagExp [3] = '{4'hB, 4'h6, 4'h4};

  tcov_keypad_model kp_u (.core_clk(core_clk), .keyWinSel(keyWinSel), .keyOnOff(keyOnOff), .keyUp(keyUp),
    .keyDown(keyDown), .keyLeft(keyLeft), .keyRight(keyRight), .remoteToggle(remoteToggle));

  tcov_ctrl dut_u (.core_clk(core_clk), .rst(rst), .keyWinSel(keyWinSel), .keyOnOff(keyOnOff), .keyUp(keyUp),
    .keyDown(keyDown), .keyLeft(keyLeft), .keyRight(keyRight), .remoteToggle(remoteToggle),
    .charSize(charSize), .charStyle(charStyle), .menuActive(menuActive), .showFrames(showFrames),
    .showFields(showFields), .showSymbols(showSymbols), .dropFrame(dropFrame), .is525(is525),
    .rdrUtcHours(rdrUtcHours), .zoneOffset(zoneOffset), .dstOn(dstOn), .vertical_reader_content_mode(mode),
    .vertical_reader_zone_select(zoneSel), .overlayOn(overlayOn), .selectMode(selectMode),
    .winHighlight(winHighlight), .winVisible(winVisible), .winEnabled(winEnabled), .winRowFlat(winRowFlat),
    .winColFlat(winColFlat), .rowLines(rowLines), .rowCount(rowCount), .glyphWhite(glyphWhite), .maskOn(maskOn),
    .maskOpaque(maskOpaque), .maskWhite(maskWhite), .frameDigitsOn(frameDigitsOn), .fieldMarkOn(fieldMarkOn),
    .symbolsOn(symbolsOn), .sepIsPeriod(sepIsPeriod), .rdrShownHours(rdrShownHours));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ************************************************************
  // compare and report
  // ************************************************************
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask : settle

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    fails = 0;
    checkCount = 0;
    rst = 1'b1;
    {charSize, charStyle, menuActive, showFrames, showFields, showSymbols, dropFrame, is525} = 11'h000;
    {rdrUtcHours, zoneOffset, dstOn, mode, zoneSel} = 14'h0000;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    settle();
    chk("overlay reset", 30'h1, overlayOn);
    chk("enable reset", 30'h3F, winEnabled);
    for (int s = 0; s < 3; s++) begin
      charSize = s[1:0];
      settle();
      chk("row lines", s == 0 ? 30'h08 : s == 1 ? 30'h10 : 30'h20, rowLines);
      chk("row count", s == 0 ? 30'h1E : s == 1 ? 30'h0F : 30'h07, rowCount);
    end
    charSize = 2'h1;
    for (int s = 0; s < 6; s++) begin
      charStyle = s[2:0];
      settle();
      chk("style", styleExp[s], {glyphWhite, maskOn, maskOpaque, maskWhite});
    end
    menuActive = 1'b1;
    settle();
    chk("menu style", 30'hE, {glyphWhite, maskOn, maskOpaque, maskWhite});
    menuActive = 1'b0;
    for (int f = 0; f < 3; f++) begin
      {showFrames, showFields, showSymbols, dropFrame, is525} = flagIn[f];
      settle();
      chk("show flags", flagExp[f], {frameDigitsOn, fieldMarkOn, symbolsOn, sepIsPeriod});
    end
    {rdrUtcHours, zoneOffset, dstOn, mode, zoneSel} = {5'h17, 5'h02, 1'b1, 2'h2, 1'b1};
    settle();
    chk("local hours wrap", 30'h02, rdrShownHours);
    {rdrUtcHours, zoneOffset, dstOn} = {5'h01, 5'h1B, 1'b0};
    settle();
    chk("local hours negative", 30'h14, rdrShownHours);
    zoneSel = 1'b0;
    settle();
    chk("utc hours", 30'h01, rdrShownHours);
    mode = 2'h0;
    zoneSel = 1'b1;
    settle();
    chk("non time-date hours", 30'h01, rdrShownHours);
    kp_u.press(K_SEL);
    chk("select mode", 30'h1, selectMode);
    chk("highlight time", 30'h01, winHighlight);
    chk("all shown", 30'h3F, winVisible);
    kp_u.press(K_DOWN);
    chk("rows one window", 30'h00000001, winRowFlat);
    kp_u.press(K_SEL);
    chk("highlight source", 30'h02, winHighlight);
    kp_u.press(K_ONOFF);
    chk("window enables", 30'h3D, winEnabled);
    chk("overlay kept", 30'h1, overlayOn);
    chk("select shows all", 30'h3F, winVisible);
    for (int w = 0; w < 4; w++) begin
      kp_u.press(K_SEL);
    end
    chk("highlight last", 30'h20, winHighlight);
    kp_u.press(K_SEL);
    chk("select left", 30'h0, selectMode);
    chk("no highlight", 30'h00, winHighlight);
    chk("enabled shown", 30'h3D, winVisible);
    kp_u.press(K_DOWN);
    chk("rows all shown", {5'h01, 5'h01, 5'h01, 5'h01, 5'h00, 5'h02}, winRowFlat);
    kp_u.press(K_RIGHT);
    chk("cols all shown", {6'h01, 6'h01, 6'h01, 6'h01, 6'h00, 6'h01}, winColFlat);
    kp_u.press(K_LEFT | K_RIGHT);
    chk("left beats right", 36'h0, winColFlat);
    kp_u.press(K_UP | K_DOWN);
    chk("up beats down", 30'h00000001, winRowFlat);
    kp_u.press(K_UP);
    chk("top row refused", 30'h00000000, winRowFlat);
    kp_u.press(K_ONOFF);
    chk("front toggle", 30'h0, overlayOn);
    chk("nothing shown", 30'h00, winVisible);
    kp_u.press(K_REMOTE);
    chk("remote toggle", 30'h1, overlayOn);
    kp_u.press(K_ONOFF | K_REMOTE);
    chk("joint toggle", 30'h0, overlayOn);
    print_verdict();
  end

  // hang guard: counts as a mismatch and ends through the same report
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule : tb_timecode_char_overlay_control
